// ---- hw/ric_ctrl.sv ----
// Reference interrupt clearing and phase offset control register bank
//
// Added by the designer: the Wishbone register port.
`include "ric_consts.svh"

module ric_ctrl #(
   parameter int PHASE_W = 32,   // Accumulated phase offset width
   parameter int STEP_W  = 16    // Step size width (register pair)
) (
   // Clock and reset
   input  wire logic                       clk_sys_in,
   input  wire logic                       nrst_in,
   // Classic Wishbone slave
   input  wire logic                       wb_cyc_in,
   input  wire logic                       wb_stb_in,
   input  wire logic                       wb_we_in,
   input  wire logic [3:0]                 wb_sel_in,
   input  wire logic [13:0]                wb_adr_in,
   input  wire logic [31:0]                wb_dat_in,
   output logic      [31:0]                wb_dat_out,
   output logic                            wb_ack_out,
   // Reference monitor events, one struct per reference A..D
   input  wire ric_pkg::ric_ref_evt_s [3:0] ref_event_in,
   // Raw fault indications of references A..D
   input  wire logic [3:0]                 ref_fault_in,
   // Fault indications after override and bypass
   output logic      [3:0]                 ref_fault_out,
   // Monitor bypass controls for references A..D
   output logic      [3:0]                 ref_bypass_out,
   // One-cycle forced timeout strobes to the validation timers
   output logic      [3:0]                 force_timeout_out,
   // Accumulated incremental phase offset, two's complement
   output logic      [PHASE_W-1:0]         phase_offset_out,
   // Interrupt request, level, active high
   output logic                            irq_out
);

   // Parameter sanity: step must fit the pair and the accumulator
   // Out-of-range widths would silently truncate the step
   if (STEP_W < 1 || STEP_W > 16) begin : g_bad_step
      $error("STEP_W must be 1 to 16");
   end
   if (PHASE_W <= STEP_W || PHASE_W > 32) begin : g_bad_phase
      $error("PHASE_W must exceed STEP_W and be at most 32");
   end

   // Bundled bus request
   ric_pkg::ric_wb_req_s req;              // Request as one carrier
   logic [11:0]          idx;              // Word index of the access
   logic                 req_live;         // Request awaiting answer
   logic                 wr_now;           // Write takes effect now
   logic                 lane0;            // Low byte lane written
   logic                 lane1;            // Second byte lane written
   logic [7:0]           wbyte;            // Low byte of write data
   logic [31:0]          next_rdata;       // Read data being selected

   // Software visible storage
   logic [3:0]           override_q;       // Fault override bits
   logic [3:0]           bypass_q;         // Monitor bypass bits
   logic [15:0]          step_q;           // Step size pair
   logic [15:0]          irq_mask;         // Mask, same layout as status
   logic [15:0]          irq_stat;         // Sticky flags, clear layout
   logic [15:0]          clr_vec;          // Clear strobes, clear layout

   // Phase arithmetic
   // Kept apart from storage so the next value is easy to follow
   logic [PHASE_W-1:0]   step_ext;         // Step widened to accumulator
   logic [PHASE_W-1:0]   next_phase;       // Accumulator next value

   // Pack the request into its carrier
   always_comb begin
      req.cyc = wb_cyc_in;
      req.stb = wb_stb_in;
      req.we  = wb_we_in;
      req.sel = wb_sel_in;
      req.adr = wb_adr_in;
      req.dat = wb_dat_in;
   end

   // Decode: word index and strobes
   // Address bits [1:0] are ignored; byte lanes come from sel
   always_comb begin
      idx      = req.adr[13:`RIC_ADR_LSB];
      req_live = req.cyc & req.stb;
      // Commit only at the edge where ack is seen by the master
      wr_now   = req_live & req.we & wb_ack_out;
      lane0    = req.sel[0];
      lane1    = req.sel[1];
      wbyte    = req.dat[7:0];
   end

   // Acknowledge one cycle after the strobe, drop it the cycle after
   // Fixed single wait state: every access, mapped or not, is answered
   // Ack gating its own next value stops a held strobe double-acking
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wb_ack_out <= 1'b0;
      end else begin
         wb_ack_out <= req_live & ~wb_ack_out;
      end
   end

   // Read data mux; unmapped and write-only words read as zero
   // No bus error exists, so a stray address simply returns zero
   always_comb begin
      next_rdata = `RIC_RST_WORD;
      case (idx)
         // Clearing and action registers hold nothing to read back
         `RIC_IDX_AB_CLR,
         `RIC_IDX_CD_CLR,
         `RIC_IDX_PH_CTRL,
         `RIC_IDX_FORCE: begin
            next_rdata = `RIC_RST_WORD;
         end
         // Override bits, reserved bits read zero
         `RIC_IDX_OVERRIDE: begin
            next_rdata[3:0] = override_q;
         end
         // Bypass bits, reserved bits read zero
         `RIC_IDX_BYPASS: begin
            next_rdata[3:0] = bypass_q;
         end
         // Step size low byte
         `RIC_IDX_STEP_LO: begin
            next_rdata[7:0] = step_q[7:0];
         end
         // Step size high byte
         `RIC_IDX_STEP_HI: begin
            next_rdata[7:0] = step_q[15:8];
         end
         // Pending flags
         `RIC_IDX_IRQ_STAT: begin
            next_rdata[15:0] = irq_stat;
         end
         // Interrupt mask
         `RIC_IDX_IRQ_MASK: begin
            next_rdata[15:0] = irq_mask;
         end
         // Current accumulated phase offset, sign-extended
         `RIC_IDX_PH_VALUE: begin
            next_rdata = 32'(signed'(phase_offset_out));
         end
         default: begin
            next_rdata = `RIC_RST_WORD;
         end
      endcase
   end

   // Read data captured in the cycle the ack is raised
   // Zero outside the ack cycle so stale data never sits on the bus
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wb_dat_out <= `RIC_RST_WORD;
      end else if (req_live & ~wb_ack_out) begin
         wb_dat_out <= next_rdata;
      end else begin
         wb_dat_out <= `RIC_RST_WORD;
      end
   end

   // Fault override register
   // Only the low nibble is stored; upper bits are reserved
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         override_q <= `RIC_RST_NIBBLE;
      end else if (wr_now && lane0 && idx == `RIC_IDX_OVERRIDE) begin
         override_q <= wbyte[3:0];
      end
   end

   // Monitor bypass register; upper bits are not stored
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         bypass_q <= `RIC_RST_NIBBLE;
      end else if (wr_now && lane0 && idx == `RIC_IDX_BYPASS) begin
         bypass_q <= wbyte[3:0];
      end
   end

   // Step size pair, one byte per register
   // Not atomic: a step taken between the two byte writes uses a
   // half-updated value, so software loads both bytes first
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         step_q <= `RIC_RST_HALF;
      end else if (wr_now && lane0) begin
         if (idx == `RIC_IDX_STEP_LO) begin
            step_q[7:0] <= wbyte;
         end else if (idx == `RIC_IDX_STEP_HI) begin
            step_q[15:8] <= wbyte;
         end
      end
   end

   // Interrupt mask; unimplemented positions are held at zero
   // Reserved positions forced low can never raise the interrupt
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_mask <= `RIC_RST_HALF;
      end else if (wr_now && idx == `RIC_IDX_IRQ_MASK) begin
         if (lane0) begin
            irq_mask[7:0] <= wbyte & `RIC_FLAG_LO_MASK;
         end
         if (lane1) begin
            irq_mask[15:8] <= req.dat[15:8] & `RIC_FLAG_HI_MASK;
         end
      end
   end

   // Clear strobes: clearing registers or a one written to status
   // Both paths merge so the clearing registers and a one written
   // to the status word behave identically
   always_comb begin
      clr_vec = `RIC_RST_HALF;
      if (wr_now && lane0 && idx == `RIC_IDX_AB_CLR) begin
         clr_vec[7:0] = wbyte;
      end
      if (wr_now && lane0 && idx == `RIC_IDX_CD_CLR) begin
         clr_vec[15:8] = wbyte;
      end
      if (wr_now && idx == `RIC_IDX_IRQ_STAT) begin
         clr_vec[7:0]  = clr_vec[7:0] | (lane0 ? wbyte : 8'h00);
         clr_vec[15:8] = clr_vec[15:8]
                       | (lane1 ? req.dat[15:8] : 8'h00);
      end
      // Reserved positions never reach a flag
      clr_vec = clr_vec & `RIC_FLAG_LAYOUT;
   end

   // One flag group per reference; A,B share one byte, C,D the next
   // Set wins inside the flag cell, so an event racing a clear is kept
   for (genvar r = 0; r < 4; r++) begin : g_ref
      localparam int BASE = (r / 2) * `RIC_BYTE + (r % 2) * `RIC_NIBBLE;
      ric_pkg::ric_ref_evt_s clr_r;       // Clears for this reference
      ric_pkg::ric_ref_evt_s flag_r;      // Flags of this reference

      // Zero bits leave the matching flag alone
      assign clr_r.fault         = clr_vec[BASE + `RIC_EVT_FAULT];
      assign clr_r.fault_cleared = clr_vec[BASE + `RIC_EVT_CLEARED];
      assign clr_r.validated     = clr_vec[BASE + `RIC_EVT_VALID];

      ric_ref_flags u_flags (
         .clk_sys_in (clk_sys_in),
         .nrst_in    (nrst_in),
         .set_in     (ref_event_in[r]),
         .clr_in     (clr_r),
         .flag_out   (flag_r)
      );

      // Place flags in the clearing layout; gap bit reads zero
      assign irq_stat[BASE + `RIC_EVT_FAULT]   = flag_r.fault;
      assign irq_stat[BASE + `RIC_EVT_CLEARED] = flag_r.fault_cleared;
      assign irq_stat[BASE + `RIC_EVT_VALID]   = flag_r.validated;
      assign irq_stat[BASE + `RIC_EVT_GAP]     = 1'b0;
   end

   // Interrupt level, registered so it comes from a flip-flop
   // Costs one cycle against status but the pin never glitches
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(irq_stat & irq_mask);
      end
   end

   // Step widened with zeros; it is a magnitude, never signed
   // Bits above STEP_W are ignored when STEP_W is below the pair
   always_comb begin
      step_ext = PHASE_W'(step_q[STEP_W-1:0]);
   end

   // Phase accumulator next value
   // Inc and dec in one write cancel, leaving the offset unchanged
   always_comb begin
      next_phase = phase_offset_out;
      if (wr_now && lane0 && idx == `RIC_IDX_PH_CTRL) begin
         if (wbyte[`RIC_PH_RST_BIT]) begin
            // Reset wins over a step written in the same access
            next_phase = '0;
         end else begin
            if (wbyte[`RIC_PH_INC_BIT]) begin
               next_phase = next_phase + step_ext;
            end
            if (wbyte[`RIC_PH_DEC_BIT]) begin
               next_phase = next_phase - step_ext;
            end
         end
      end
   end

   // Accumulator; wraps modulo its width, no saturation
   // Wrap keeps the logic small; software must bound its own stepping
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         phase_offset_out <= '0;
      end else begin
         phase_offset_out <= next_phase;
      end
   end

   // Forced timeout strobes last exactly one cycle
   // The validation timer lives outside; only the pulse leaves here
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         force_timeout_out <= `RIC_RST_NIBBLE;
      end else if (wr_now && lane0 && idx == `RIC_IDX_FORCE) begin
         force_timeout_out <= wbyte[3:0];
      end else begin
         // Self-clear: nothing is held once the strobe has gone
         force_timeout_out <= `RIC_RST_NIBBLE;
      end
   end

   // Fault seen downstream: override or bypass suppresses it
   // One cycle of latency buys a clean flip-flop output
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ref_fault_out <= `RIC_RST_NIBBLE;
      end else begin
         ref_fault_out <= ref_fault_in & ~override_q & ~bypass_q;
      end
   end

   // Bypass control handed to the monitors
   // Follows the register one cycle after the write commits
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ref_bypass_out <= `RIC_RST_NIBBLE;
      end else begin
         ref_bypass_out <= bypass_q;
      end
   end

endmodule

// ---- hw/ric_consts.svh ----
// Register indices, field positions and reset values of the control bank
`ifndef RIC_CONSTS_SVH
`define RIC_CONSTS_SVH

// Register indices; the byte address is four times the index
`define RIC_IDX_AB_CLR    12'hA08
`define RIC_IDX_CD_CLR    12'hA09
`define RIC_IDX_PH_CTRL   12'hA0A
`define RIC_IDX_FORCE     12'hA0B
`define RIC_IDX_OVERRIDE  12'hA0C
`define RIC_IDX_BYPASS    12'hA0D
`define RIC_IDX_STEP_LO   12'h312
`define RIC_IDX_STEP_HI   12'h313
`define RIC_IDX_IRQ_STAT  12'hA0E
`define RIC_IDX_IRQ_MASK  12'hA0F
`define RIC_IDX_PH_VALUE  12'hA10

// Byte lane offset of the word index within a Wishbone address
`define RIC_ADR_LSB       2

// Phase offset control fields
`define RIC_PH_INC_BIT    0
`define RIC_PH_DEC_BIT    1
`define RIC_PH_RST_BIT    2

// Per-reference flag positions inside a clearing nibble
`define RIC_EVT_FAULT     0
`define RIC_EVT_CLEARED   1
`define RIC_EVT_VALID     2
`define RIC_EVT_GAP       3

// Bit distance between references sharing a clearing register, and between the A,B and C,D groups
`define RIC_NIBBLE        4
`define RIC_BYTE          8

// Implemented flag bits of the 16-bit status layout
`define RIC_FLAG_LAYOUT   16'h7777
// The same layout split into its two byte lanes
`define RIC_FLAG_LO_MASK  8'h77
`define RIC_FLAG_HI_MASK  8'h77

// Reset values
`define RIC_RST_NIBBLE    4'h0
`define RIC_RST_BYTE      8'h00
`define RIC_RST_HALF      16'h0000
`define RIC_RST_WORD      32'h0000_0000

`endif

// ---- hw/ric_pkg.sv ----
// Types shared by the reference interrupt and phase offset control bank
package ric_pkg;

   // Events reported by one reference monitor
   typedef struct packed {
      logic validated;       // Reference passed validation
      logic fault_cleared;   // Fault condition went away
      logic fault;           // Fault condition appeared
   } ric_ref_evt_s;

   // Classic Wishbone request, as the slave sees it
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [13:0] adr;
      logic [31:0] dat;
   } ric_wb_req_s;

endpackage

// ---- hw/ric_ref_flags.sv ----
// Sticky interrupt flags of one reference input
`include "ric_consts.svh"

module ric_ref_flags (
   // Clock and reset
   input  wire logic                 clk_sys_in,
   input  wire logic                 nrst_in,
   // Event pulses from the reference monitor
   input  wire ric_pkg::ric_ref_evt_s set_in,
   // Clear strobes from software writes
   input  wire ric_pkg::ric_ref_evt_s clr_in,
   // Flag state
   output ric_pkg::ric_ref_evt_s      flag_out
);

   // Set dominates clear so an event landing on a clear is kept
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         flag_out <= '0;
      end else begin
         flag_out <= set_in | (flag_out & ~clr_in);
      end
   end

endmodule

// ---- verification/ric_ctrl_assertions.sv ----
// Concurrent checks on the ports of the control register bank
`include "ric_consts.svh"

module ric_ctrl_assertions #(
   parameter int PHASE_W = 32,   // Accumulator width
   parameter int STEP_W  = 16    // Step width
) (
   input wire logic               clk_sys_in,
   input wire logic               nrst_in,
   input wire logic               wb_cyc_in,
   input wire logic               wb_stb_in,
   input wire logic               wb_we_in,
   input wire logic [3:0]         wb_sel_in,
   input wire logic [13:0]        wb_adr_in,
   input wire logic [31:0]        wb_dat_in,
   input wire logic [31:0]        wb_dat_out,
   input wire logic               wb_ack_out,
   input wire logic [3:0]         ref_fault_in,
   input wire logic [3:0]         ref_fault_out,
   input wire logic [3:0]         ref_bypass_out,
   input wire logic [3:0]         force_timeout_out,
   input wire logic [PHASE_W-1:0] phase_offset_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);

   logic        wr;        // Write commits at this edge
   logic        rd;        // Read answered at this edge
   logic [11:0] idx;       // Word index of the request
   logic [15:0] step;      // Shadow of the step size pair
   logic [3:0]  byp_exp;   // Shadow of the bypass bits

   assign idx = wb_adr_in[13:2];
   assign wr = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out
               && wb_sel_in[0];
   assign rd = wb_cyc_in && wb_stb_in && !wb_we_in && wb_ack_out;

   // Shadow registers; the step itself is not visible at the ports
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         step    <= 16'h0000;
         byp_exp <= 4'h0;
      end else if (wr) begin
         if (idx == `RIC_IDX_STEP_LO) step[7:0] <= wb_dat_in[7:0];
         if (idx == `RIC_IDX_STEP_HI) step[15:8] <= wb_dat_in[7:0];
         if (idx == `RIC_IDX_BYPASS) byp_exp <= wb_dat_in[3:0];
      end
   end

   // Committed write to one register
   sequence s_wr(logic [11:0] i);
      wr && idx == i;
   endsequence

   AST_ACK_ONE: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
      |=> wb_ack_out) else $error("ack late");
   AST_ACK_DROP: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack held");
   AST_RD_WO: assert property (rd && idx >= `RIC_IDX_AB_CLR &&
      idx <= `RIC_IDX_FORCE |-> wb_dat_out == 32'h0000_0000)
      else $error("action bit reads back");
   AST_FORCE: assert property (s_wr(`RIC_IDX_FORCE) |=>
      force_timeout_out == $past(wb_dat_in[3:0]))
      else $error("forced timeout strobe wrong");
   AST_FORCE_IDLE: assert property (force_timeout_out != 4'h0 |->
      $past(wr && idx == `RIC_IDX_FORCE)) else $error("stray strobe");
   AST_PH_RST: assert property (s_wr(`RIC_IDX_PH_CTRL) ##0
      wb_dat_in[2] |=> phase_offset_out == '0)
      else $error("offset not zeroed");
   AST_PH_INC: assert property (s_wr(`RIC_IDX_PH_CTRL) ##0
      wb_dat_in[2:0] == 3'h1 |=> phase_offset_out ==
      $past(phase_offset_out) + PHASE_W'(step[STEP_W-1:0]))
      else $error("inc wrong");
   AST_PH_DEC: assert property (s_wr(`RIC_IDX_PH_CTRL) ##0
      wb_dat_in[2:0] == 3'h2 |=> phase_offset_out ==
      $past(phase_offset_out) - PHASE_W'(step[STEP_W-1:0]))
      else $error("dec wrong");
   AST_PH_HOLD: assert property (!(wr && idx == `RIC_IDX_PH_CTRL)
      |=> $stable(phase_offset_out)) else $error("offset drifted");
   AST_FAULT: assert property ((ref_fault_out &
      ~$past(ref_fault_in)) == 4'h0) else $error("fault without cause");
   AST_BYP: assert property (s_wr(`RIC_IDX_BYPASS) |->
      ##[1:2] ref_bypass_out == byp_exp) else $error("bypass not taken");
   AST_BYP_FAULT: assert property ((ref_fault_out &
      ref_bypass_out) == 4'h0) else $error("bypassed fault seen");
endmodule

bind ric_ctrl ric_ctrl_assertions #(.PHASE_W(PHASE_W), .STEP_W(STEP_W))
   u_ric_ctrl_assertions (.clk_sys_in, .nrst_in, .wb_cyc_in, .wb_stb_in,
   .wb_we_in, .wb_sel_in, .wb_adr_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
   .ref_fault_in, .ref_fault_out, .ref_bypass_out, .force_timeout_out,
   .phase_offset_out);

// ---- verification/ric_ctrl_tb.sv ----
// Self-checking bench of the control register bank
`include "ric_consts.svh"

module ric_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                        clk_sys_in = 1'b0;
   logic                        nrst_in = 1'b0;
   logic                        wb_cyc_in = 1'b0;
   logic                        wb_stb_in = 1'b0;
   logic                        wb_we_in = 1'b0;
   logic [3:0]                  wb_sel_in = 4'h0;
   logic [13:0]                 wb_adr_in = 14'h0000;
   logic [31:0]                 wb_dat_in = 32'h0000_0000;
   logic [31:0]                 wb_dat_out, phase_offset_out;
   logic                        wb_ack_out, irq_out;
   ric_pkg::ric_ref_evt_s [3:0] ref_event_in = 12'h000;
   logic [3:0]                  ref_fault_in = 4'h0;
   logic [3:0]                  ref_fault_out, ref_bypass_out;
   logic [3:0]                  force_timeout_out;
   int                          error_cnt = 0;
   int                          n_compared = 0;
   logic [31:0]                 s, cb;   // Expected flag, clear mask
   logic [11:0]                 ci;      // Clearing register index

   ric_ctrl u_ric_ctrl (.clk_sys_in, .nrst_in, .wb_cyc_in, .wb_stb_in,
      .wb_we_in, .wb_sel_in, .wb_adr_in, .wb_dat_in, .wb_dat_out,
      .wb_ack_out, .ref_event_in, .ref_fault_in, .ref_fault_out,
      .ref_bypass_out, .force_timeout_out, .phase_offset_out, .irq_out);

   // 50 MHz system clock
   initial forever #10 clk_sys_in = ~clk_sys_in;

   // Compare and count
   task automatic chk(input logic [31:0] got, exp, input string m);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got,
            exp);
      end
   endtask

   // One classic cycle; waits for ack, bounded by a count
   task automatic xfer(input logic we, input logic [11:0] i,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_sys_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in  <= we;
      wb_sel_in <= 4'hF;
      wb_adr_in <= {i, 2'b00};
      wb_dat_in <= d;
      n = 0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (wb_ack_out !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         $display("wrong value at %0t: no ack", $time);
      end
      q = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      wb_we_in  <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] i, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, i, d, q);
   endtask

   task automatic rd(input logic [11:0] i, input logic [31:0] e,
      input string m);
      logic [31:0] q;
      xfer(1'b0, i, 32'h0000_0000, q);
      chk(q, e, m);
   endtask

   // One-cycle event pulse on reference r, flag b
   task automatic ev(input int r, input int b);
      @(posedge clk_sys_in) ref_event_in[r] <= 3'(1 << b);
      @(posedge clk_sys_in) ref_event_in <= 12'h000;
      repeat (3) @(posedge clk_sys_in);
   endtask

   // Report and stop
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Hang guard, far beyond the length of the tests
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      error_cnt++;
      finish_test();
   end

   // Main sequence
   initial begin
      repeat (5) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      rd(`RIC_IDX_OVERRIDE, 32'h0, "override reset");
      rd(`RIC_IDX_BYPASS, 32'h0, "bypass reset");
      wr(`RIC_IDX_AB_CLR, 32'hFF);
      rd(`RIC_IDX_AB_CLR, 32'h0, "clear reads");
      rd(12'h7FF, 32'h0, "unmapped");
      $display("reset test done");
      // Every flag of every reference: set, zero write, clear
      wr(`RIC_IDX_IRQ_MASK, 32'hFFFF);
      rd(`RIC_IDX_IRQ_MASK, 32'h7777, "mask reserved");
      for (int r = 0; r < 4; r++) begin
         for (int b = 0; b < 3; b++) begin
            ev(r, b);
            s  = 32'h1 << (r * 4 + b);
            ci = (r < 2) ? `RIC_IDX_AB_CLR : `RIC_IDX_CD_CLR;
            cb = 32'h1 << ((r % 2) * 4 + b);
            rd(`RIC_IDX_IRQ_STAT, s, "flag set");
            chk(32'(irq_out), 32'h1, "irq high");
            wr(ci, ~cb & 32'hFF);
            rd(`RIC_IDX_IRQ_STAT, s, "flag kept");
            wr(ci, cb);
            rd(`RIC_IDX_IRQ_STAT, 32'h0, "cleared");
            chk(32'(irq_out), 32'h0, "irq low");
         end
      end
      wr(`RIC_IDX_IRQ_MASK, 32'h0);
      ev(0, 0);
      rd(`RIC_IDX_IRQ_STAT, 32'h1, "masked flag");
      chk(32'(irq_out), 32'h0, "masked irq");
      wr(`RIC_IDX_IRQ_STAT, 32'h1);
      rd(`RIC_IDX_IRQ_STAT, 32'h0, "status w1c");
      $display("interrupt test done");
      // Phase offset steps
      wr(`RIC_IDX_STEP_LO, 32'h34);
      wr(`RIC_IDX_STEP_HI, 32'h12);
      rd(`RIC_IDX_STEP_LO, 32'h34, "step lo");
      rd(`RIC_IDX_STEP_HI, 32'h12, "step hi");
      wr(`RIC_IDX_PH_CTRL, 32'h1);
      wr(`RIC_IDX_PH_CTRL, 32'h1);
      @(negedge clk_sys_in) chk(phase_offset_out, 32'h2468, "inc");
      for (int k = 0; k < 3; k++) wr(`RIC_IDX_PH_CTRL, 32'h2);
      rd(`RIC_IDX_PH_VALUE, 32'hFFFF_EDCC, "dec");
      wr(`RIC_IDX_PH_CTRL, 32'h0);
      rd(`RIC_IDX_PH_VALUE, 32'hFFFF_EDCC, "zero write");
      wr(`RIC_IDX_PH_CTRL, 32'h3);
      rd(`RIC_IDX_PH_VALUE, 32'hFFFF_EDCC, "inc and dec");
      wr(`RIC_IDX_PH_CTRL, 32'h5);
      @(negedge clk_sys_in) chk(phase_offset_out, 32'h0, "reset");
      $display("phase test done");
      // Forced timeout strobes last one cycle
      wr(`RIC_IDX_FORCE, 32'hFA);
      @(negedge clk_sys_in);
      chk(32'(force_timeout_out), 32'hA, "force");
      @(negedge clk_sys_in);
      chk(32'(force_timeout_out), 32'h0, "force end");
      // Override and bypass mask the raw faults
      @(posedge clk_sys_in) ref_fault_in <= 4'hF;
      wr(`RIC_IDX_OVERRIDE, 32'hF1);
      rd(`RIC_IDX_OVERRIDE, 32'h1, "override rb");
      chk(32'(ref_fault_out), 32'hE, "override");
      wr(`RIC_IDX_BYPASS, 32'hF2);
      rd(`RIC_IDX_BYPASS, 32'h2, "bypass rb");
      chk(32'(ref_bypass_out), 32'h2, "bypass out");
      chk(32'(ref_fault_out), 32'hC, "bypass");
      $display("monitor test done");
      finish_test();
   end
endmodule
